// ==== arf_branch_model.sv ====
// Branch-resolution side model that drives the speculation pulses.
module arf_branch_model (
    input wire logic clk,
    input wire logic br_stall,
    output logic br_issue,
    output logic br_resolve,
    output logic br_mispredict
);
    timeunit 1ns;
    timeprecision 100ps;
    initial begin
        {br_mispredict, br_resolve, br_issue} = 3'h0;
    end
    // Holds a new branch off while the tracker is full, for at most 50 cycles, unless told to push on regardless.
    // Signals stay set until the next call, so back-to-back calls never assign twice at one edge.
    task automatic pulse(input logic [2:0] kind, input bit pushy);
        int n;
        n = 0;
        while (br_stall && kind[0] && !pushy && n < 50) begin
            @(negedge clk);
            n++;
        end
        {br_mispredict, br_resolve, br_issue} = kind;
        @(negedge clk);
    endtask
endmodule

// ==== arf_consts.svh ====
// Constants and rule summary for the architectural register file.
// Function
// - Hold architectural commits until all older speculative branches are resolved.
// - On misprediction, roll back to the branch and restore every register; the code rolls back to the oldest outstanding branch instead.
// - At most seven unresolved branches; further branches stall until a slot frees; the code raises BR_STALL and drops an issue that comes while full.
// - Eight 32-bit general-purpose registers for integers or pointers.
// - Accumulator, base, count and I/O registers expose low 16-bit views.
// - Those four word views also expose high and low byte views.
// - Pointer registers expose only a low 16-bit view, no byte views.
// - Six 16-bit segment registers: code, four data, one stack.
// - Real mode uses the segment value directly to form the base.
// - Protected mode uses the segment value as a descriptor selector.
// - Instruction pointer tracks next instruction, 32-bit or 16-bit wide.
// - Instruction pointer changes only through control transfers; the code also loads it from IP_DATA on ARF_IP_SEQ.
// - Eight 80-bit float registers plus status, control and tag words.
// - Float status word is a 16-bit register of unit state.
// - Eight 64-bit media registers share float register storage.
// - Flags hold system controls, a direction control and status results.
// - Five control registers hold system control bits and pointers.
`ifndef ARF_CONSTS_SVH
`define ARF_CONSTS_SVH
`define ARF_MAX_BRANCHES 7
`define ARF_SEG_SHIFT 4
`define ARF_SEL_INDEX_LSB 3
`define ARF_FLAGS_RESET 32'h0000_0002
`define ARF_CTRL0_RESET 32'h6000_0010
`define ARF_FCW_RESET 16'h037f
`define ARF_FTW_RESET 16'hffff
`define ARF_CS_RESET 16'hf000
`define ARF_IP_RESET 32'h0000_fff0
`define ARF_IP16_MASK 32'h0000_ffff
`define ARF_MEDIA_EXP 16'hffff
`define ARF_DIR_BIT 10
`endif

// ==== arf_pkg.sv ====
// Types for the architectural register file.
package arf_pkg;
    typedef enum logic [1:0] {ARF_W32, ARF_W16, ARF_B_HI, ARF_B_LO} arf_width_t;
    typedef enum logic [1:0] {ARF_IP_NONE, ARF_IP_SEQ, ARF_IP_XFER} arf_ipop_t;
    typedef struct packed {
        logic en;
        logic [2:0] idx;
        arf_width_t width;
        logic [31:0] data;
    } arf_gpr_wr_t;
    typedef struct packed {
        logic en;
        logic [2:0] idx;
        logic [79:0] data;
    } arf_fpr_wr_t;
    typedef struct packed {
        logic en;
        logic [2:0] idx;
        logic [63:0] data;
    } arf_media_wr_t;
    typedef struct packed {
        logic [31:0] insn_pointer32;
        logic [15:0] cs;
        logic [15:0] ds;
        logic [15:0] es;
        logic [15:0] fs;
        logic [15:0] gs;
        logic [15:0] ss;
    } arf_seg_t;
endpackage

// ==== arf_regfile.sv ====
// Architectural register state with speculation checkpoints and rollback.
`include "arf_consts.svh"
module arf_regfile
    import arf_pkg::*;
#(
    parameter int MAX_BR = `ARF_MAX_BRANCHES
) (
    input wire logic CLK_SYS,
    input wire logic RST,
    input wire arf_gpr_wr_t GPR_WR,
    input wire arf_fpr_wr_t FPR_WR,
    input wire arf_media_wr_t MEDIA_WR,
    input wire logic SEG_WR_EN,
    input wire logic [2:0] SEG_WR_IDX,
    input wire logic [15:0] SEG_WR_DATA,
    input wire logic FLAGS_WR_EN,
    input wire logic [31:0] FLAGS_WR_DATA,
    input wire logic CTRL_WR_EN,
    input wire logic [2:0] CTRL_WR_IDX,
    input wire logic [31:0] CTRL_WR_DATA,
    input wire logic FSW_WR_EN,
    input wire logic [15:0] FSW_WR_DATA,
    input wire logic FCW_WR_EN,
    input wire logic [15:0] FCW_WR_DATA,
    input wire logic FTW_WR_EN,
    input wire logic [15:0] FTW_WR_DATA,
    input wire arf_ipop_t IP_OP,
    input wire logic [31:0] IP_DATA,
    input wire logic OPSIZE32,
    input wire logic BR_ISSUE,
    input wire logic BR_RESOLVE,
    input wire logic BR_MISPREDICT,
    input wire logic [2:0] RD_GPR_IDX,
    input wire arf_width_t RD_GPR_WIDTH,
    input wire logic [2:0] RD_FPR_IDX,
    input wire logic [2:0] RD_SEG_IDX,
    input wire logic [2:0] RD_CTRL_IDX,
    output logic [31:0] RD_GPR_DATA,
    output logic [79:0] RD_FPR_DATA,
    output logic [63:0] RD_MEDIA_DATA,
    output logic [15:0] RD_SEG_DATA,
    output logic [31:0] RD_SEG_BASE,
    output logic [12:0] RD_SEG_SEL_INDEX,
    output logic RD_SEG_SEL_TABLE,
    output logic [1:0] RD_SEG_SEL_RPL,
    output logic [31:0] RD_CTRL_DATA,
    output logic [31:0] FLAGS,
    output logic [15:0] FSW,
    output logic [15:0] FCW,
    output logic [15:0] FTW,
    output logic [31:0] INSN_PTR,
    output logic SPEC_PENDING,
    output logic BR_STALL,
    output logic [2:0] BR_COUNT
);
    initial begin
        if (MAX_BR < 1 || MAX_BR > 7) begin
            $error("MAX_BR must be 1 to 7");
        end
    end

    // Narrow-view merge; index 0..3 own byte views, 4..7 only word views.
    function automatic logic [31:0] gpr_merge(input logic [31:0] old, input logic [2:0] idx,
                                              input arf_width_t w, input logic [31:0] d);
        logic [31:0] r;
        r = old;
        case (w)
            ARF_W32: r = d;
            ARF_W16: r = {old[31:16], d[15:0]};
            ARF_B_HI: r = idx[2] ? old : {old[31:16], d[7:0], old[7:0]};
            ARF_B_LO: r = idx[2] ? old : {old[31:8], d[7:0]};
            default: r = old;
        endcase
        return r;
    endfunction

    function automatic logic [31:0] gpr_view(input logic [31:0] v, input logic [2:0] idx,
                                             input arf_width_t w);
        logic [31:0] r;
        r = 32'h0000_0000;
        case (w)
            ARF_W32: r = v;
            ARF_W16: r = {16'h0000, v[15:0]};
            ARF_B_HI: r = idx[2] ? 32'h0000_0000 : {24'h00_0000, v[15:8]};
            ARF_B_LO: r = idx[2] ? 32'h0000_0000 : {24'h00_0000, v[7:0]};
            default: r = 32'h0000_0000;
        endcase
        return r;
    endfunction

    // Working (speculative) state. The media registers live inside fpr_reg.
    logic [31:0] gpr_reg [8];
    logic [79:0] fpr_reg [8];
    logic [15:0] seg_reg [6];
    logic [31:0] ctrl_reg [5];
    logic [31:0] flags_reg;
    logic [15:0] fsw_reg;
    logic [15:0] fcw_reg;
    logic [15:0] ftw_reg;
    logic [31:0] ip_reg;
    // Committed copy, taken only while no branch is outstanding.
    logic [31:0] c_gpr_reg [8];
    logic [79:0] c_fpr_reg [8];
    logic [15:0] c_seg_reg [6];
    logic [31:0] c_ctrl_reg [5];
    logic [31:0] c_flags_reg;
    logic [15:0] c_fsw_reg;
    logic [15:0] c_fcw_reg;
    logic [15:0] c_ftw_reg;
    logic [31:0] c_ip_reg;
    logic [2:0] br_cnt_reg;
    logic [2:0] br_cnt_next;

    // A single committed checkpoint is the oldest branch; a mispredict of any
    // outstanding branch is treated as rollback to it, trading precision for area.
    wire br_full = br_cnt_reg == 3'(MAX_BR);
    wire br_take = BR_ISSUE && !br_full;
    wire br_done = BR_RESOLVE && !BR_MISPREDICT && br_cnt_reg != 3'h0;
    wire rollback = BR_MISPREDICT && br_cnt_reg != 3'h0;
    wire commit_ok = br_cnt_next == 3'h0;

    always_comb begin
        br_cnt_next = br_cnt_reg;
        if (rollback) begin
            br_cnt_next = 3'h0;
        end else if (br_take && !br_done) begin
            br_cnt_next = br_cnt_reg + 3'h1;
        end else if (br_done && !br_take) begin
            br_cnt_next = br_cnt_reg - 3'h1;
        end
    end

    wire [31:0] ip_seq = OPSIZE32 ? IP_DATA : (IP_DATA & `ARF_IP16_MASK);
    wire [31:0] ip_next = (IP_OP == ARF_IP_NONE) ? ip_reg : ip_seq;

    // Working registers; a rollback restores every view in one edge.
    always_ff @(posedge CLK_SYS) begin
        if (RST) begin
            for (int i = 0; i < 8; i++) begin
                gpr_reg[i] <= 32'h0000_0000;
                fpr_reg[i] <= 80'h0;
            end
            for (int i = 0; i < 6; i++) begin
                seg_reg[i] <= (i == 0) ? `ARF_CS_RESET : 16'h0000;
            end
            for (int i = 0; i < 5; i++) begin
                ctrl_reg[i] <= (i == 0) ? `ARF_CTRL0_RESET : 32'h0000_0000;
            end
            flags_reg <= `ARF_FLAGS_RESET;
            fsw_reg <= 16'h0000;
            fcw_reg <= `ARF_FCW_RESET;
            ftw_reg <= `ARF_FTW_RESET;
            ip_reg <= `ARF_IP_RESET;
        end else if (rollback) begin
            gpr_reg <= c_gpr_reg;
            fpr_reg <= c_fpr_reg;
            seg_reg <= c_seg_reg;
            ctrl_reg <= c_ctrl_reg;
            flags_reg <= c_flags_reg;
            fsw_reg <= c_fsw_reg;
            fcw_reg <= c_fcw_reg;
            ftw_reg <= c_ftw_reg;
            ip_reg <= c_ip_reg;
        end else begin
            if (GPR_WR.en) begin
                gpr_reg[GPR_WR.idx] <= gpr_merge(gpr_reg[GPR_WR.idx], GPR_WR.idx,
                                                 GPR_WR.width, GPR_WR.data);
            end
            if (FPR_WR.en) begin
                fpr_reg[FPR_WR.idx] <= FPR_WR.data;
            end else if (MEDIA_WR.en) begin
                fpr_reg[MEDIA_WR.idx] <= {`ARF_MEDIA_EXP, MEDIA_WR.data};
            end
            if (SEG_WR_EN && SEG_WR_IDX < 3'h6) begin
                seg_reg[SEG_WR_IDX] <= SEG_WR_DATA;
            end
            if (CTRL_WR_EN && CTRL_WR_IDX < 3'h5) begin
                ctrl_reg[CTRL_WR_IDX] <= CTRL_WR_DATA;
            end
            if (FLAGS_WR_EN) begin
                flags_reg <= FLAGS_WR_DATA;
            end
            if (FSW_WR_EN) begin
                fsw_reg <= FSW_WR_DATA;
            end
            if (FCW_WR_EN) begin
                fcw_reg <= FCW_WR_DATA;
            end
            if (FTW_WR_EN) begin
                ftw_reg <= FTW_WR_DATA;
            end
            ip_reg <= ip_next;
        end
    end

    // The committed copy follows the working state only once nothing is speculative.
    always_ff @(posedge CLK_SYS) begin
        if (RST) begin
            for (int i = 0; i < 8; i++) begin
                c_gpr_reg[i] <= 32'h0000_0000;
                c_fpr_reg[i] <= 80'h0;
            end
            for (int i = 0; i < 6; i++) begin
                c_seg_reg[i] <= (i == 0) ? `ARF_CS_RESET : 16'h0000;
            end
            for (int i = 0; i < 5; i++) begin
                c_ctrl_reg[i] <= (i == 0) ? `ARF_CTRL0_RESET : 32'h0000_0000;
            end
            c_flags_reg <= `ARF_FLAGS_RESET;
            c_fsw_reg <= 16'h0000;
            c_fcw_reg <= `ARF_FCW_RESET;
            c_ftw_reg <= `ARF_FTW_RESET;
            c_ip_reg <= `ARF_IP_RESET;
        end else if (!rollback && commit_ok && br_cnt_reg == 3'h0) begin
            c_gpr_reg <= gpr_reg;
            c_fpr_reg <= fpr_reg;
            c_seg_reg <= seg_reg;
            c_ctrl_reg <= ctrl_reg;
            c_flags_reg <= flags_reg;
            c_fsw_reg <= fsw_reg;
            c_fcw_reg <= fcw_reg;
            c_ftw_reg <= ftw_reg;
            c_ip_reg <= ip_reg;
        end
    end

    always_ff @(posedge CLK_SYS) begin
        if (RST) begin
            br_cnt_reg <= 3'h0;
        end else begin
            br_cnt_reg <= br_cnt_next;
        end
    end

    // Segment base formation by mode; protected mode hands back selector fields.
    wire prot_mode = ctrl_reg[0][0];
    wire [15:0] seg_sel = (RD_SEG_IDX < 3'h6) ? seg_reg[RD_SEG_IDX] : 16'h0000;
    wire [31:0] seg_base = prot_mode ? 32'h0000_0000
                                     : {12'h000, seg_sel, 4'h0};

    always_ff @(posedge CLK_SYS) begin
        if (RST) begin
            RD_GPR_DATA <= 32'h0000_0000;
            RD_FPR_DATA <= 80'h0;
            RD_MEDIA_DATA <= 64'h0;
            RD_SEG_DATA <= 16'h0000;
            RD_SEG_BASE <= 32'h0000_0000;
            RD_SEG_SEL_INDEX <= 13'h0000;
            RD_SEG_SEL_TABLE <= 1'b0;
            RD_SEG_SEL_RPL <= 2'h0;
            RD_CTRL_DATA <= 32'h0000_0000;
            FLAGS <= `ARF_FLAGS_RESET;
            FSW <= 16'h0000;
            FCW <= `ARF_FCW_RESET;
            FTW <= `ARF_FTW_RESET;
            INSN_PTR <= `ARF_IP_RESET;
            SPEC_PENDING <= 1'b0;
            BR_STALL <= 1'b0;
            BR_COUNT <= 3'h0;
        end else begin
            RD_GPR_DATA <= gpr_view(gpr_reg[RD_GPR_IDX], RD_GPR_IDX, RD_GPR_WIDTH);
            RD_FPR_DATA <= fpr_reg[RD_FPR_IDX];
            RD_MEDIA_DATA <= fpr_reg[RD_FPR_IDX][63:0];
            RD_SEG_DATA <= seg_sel;
            RD_SEG_BASE <= seg_base;
            RD_SEG_SEL_INDEX <= seg_sel[15:`ARF_SEL_INDEX_LSB];
            RD_SEG_SEL_TABLE <= seg_sel[2];
            RD_SEG_SEL_RPL <= seg_sel[1:0];
            RD_CTRL_DATA <= (RD_CTRL_IDX < 3'h5) ? ctrl_reg[RD_CTRL_IDX] : 32'h0000_0000;
            FLAGS <= flags_reg;
            FSW <= fsw_reg;
            FCW <= fcw_reg;
            FTW <= ftw_reg;
            INSN_PTR <= ip_reg;
            SPEC_PENDING <= br_cnt_next != 3'h0;
            BR_STALL <= br_cnt_next == 3'(MAX_BR);
            BR_COUNT <= br_cnt_next;
        end
    end
endmodule

// ==== arf_regfile_asserts.sv ====
// Port-level checks for the architectural register file.
module arf_regfile_asserts
    import arf_pkg::*;
#(
    parameter int MAX_BR = 7
) (
    input wire logic CLK_SYS,
    input wire logic RST,
    input wire arf_ipop_t IP_OP,
    input wire logic [31:0] IP_DATA,
    input wire logic OPSIZE32,
    input wire logic BR_ISSUE,
    input wire logic BR_RESOLVE,
    input wire logic BR_MISPREDICT,
    input wire logic [79:0] RD_FPR_DATA,
    input wire logic [63:0] RD_MEDIA_DATA,
    input wire logic [31:0] INSN_PTR,
    input wire logic SPEC_PENDING,
    input wire logic BR_STALL,
    input wire logic [2:0] BR_COUNT
);
    logic [31:0] ip_exp;
    assign ip_exp = OPSIZE32 ? IP_DATA : (IP_DATA & 32'h0000_ffff);
    default clocking cb @(posedge CLK_SYS); endclocking
    default disable iff (RST);
    property p_br_cap;
        BR_COUNT <= 3'(MAX_BR);
    endproperty
    a_br_cap: assert property (p_br_cap) else $error("branch count above cap");
    property p_stall_full;
        BR_STALL == (BR_COUNT == 3'(MAX_BR));
    endproperty
    a_stall_full: assert property (p_stall_full) else $error("stall flag wrong");
    property p_issue_inc;
        BR_ISSUE && !BR_STALL && !BR_RESOLVE && !BR_MISPREDICT |=>
            BR_COUNT == $past(BR_COUNT) + 3'h1;
    endproperty
    a_issue_inc: assert property (p_issue_inc) else $error("issue not counted");
    property p_issue_refused;
        BR_ISSUE && BR_STALL && !BR_RESOLVE && !BR_MISPREDICT |=> $stable(BR_COUNT);
    endproperty
    a_issue_refused: assert property (p_issue_refused) else $error("issue past cap");
    property p_mispredict_clear;
        BR_MISPREDICT && !BR_ISSUE && BR_COUNT != 3'h0 |=> BR_COUNT == 3'h0 && !SPEC_PENDING;
    endproperty
    a_mispredict_clear: assert property (p_mispredict_clear) else $error("rollback kept branches");
    property p_pending;
        SPEC_PENDING == (BR_COUNT != 3'h0);
    endproperty
    a_pending: assert property (p_pending) else $error("pending flag wrong");
    property p_ip_hold;
        IP_OP == ARF_IP_NONE && !BR_MISPREDICT |-> ##2 $stable(INSN_PTR);
    endproperty
    a_ip_hold: assert property (p_ip_hold) else $error("pointer moved without transfer");
    property p_ip_load;
        IP_OP != ARF_IP_NONE && !BR_MISPREDICT |-> ##2 INSN_PTR == $past(ip_exp, 2);
    endproperty
    a_ip_load: assert property (p_ip_load) else $error("pointer load wrong");
    property p_media_alias;
        RD_MEDIA_DATA == RD_FPR_DATA[63:0];
    endproperty
    a_media_alias: assert property (p_media_alias) else $error("media view not aliased");
    c_stall: cover property (BR_ISSUE && BR_STALL);
    c_rollback: cover property (BR_MISPREDICT && BR_COUNT != 3'h0);
    c_xfer: cover property (IP_OP == ARF_IP_XFER);
endmodule

bind arf_regfile arf_regfile_asserts #(.MAX_BR(MAX_BR)) chk_u (.CLK_SYS(CLK_SYS), .RST(RST),
    .IP_OP(IP_OP), .IP_DATA(IP_DATA), .OPSIZE32(OPSIZE32), .BR_ISSUE(BR_ISSUE),
    .BR_RESOLVE(BR_RESOLVE), .BR_MISPREDICT(BR_MISPREDICT), .RD_FPR_DATA(RD_FPR_DATA),
    .RD_MEDIA_DATA(RD_MEDIA_DATA), .INSN_PTR(INSN_PTR), .SPEC_PENDING(SPEC_PENDING),
    .BR_STALL(BR_STALL), .BR_COUNT(BR_COUNT));

// ==== tb.sv ====
// Self-checking bench for the architectural register file.
module tb;
    timeunit 1ns;
    timeprecision 100ps;
    import arf_pkg::*;
    localparam int MAX_BR = 7;
    logic clk_sys = 1'b0, rst = 1'b1, seg_en = 1'b0, flags_en = 1'b0, ctrl_en = 1'b0;
    arf_gpr_wr_t gpr_wr = '0;
    arf_fpr_wr_t fpr_wr = '0;
    arf_media_wr_t media_wr = '0;
    logic [2:0] seg_idx = 3'h0, ctrl_idx = 3'h0, fw_en = 3'h0, rd_gpr_idx = 3'h0;
    logic [2:0] rd_fpr_idx = 3'h0, rd_seg_idx = 3'h0, rd_ctrl_idx = 3'h0;
    logic [15:0] seg_data = 16'h0000, fw_data = 16'h0000;
    logic [31:0] flags_data = 32'h0, ctrl_data = 32'h0, ip_data = 32'h0;
    arf_ipop_t ip_op = ARF_IP_NONE;
    arf_width_t rd_width = ARF_W32;
    logic opsize32 = 1'b1;
    logic br_issue, br_resolve, br_mispredict, sel_tbl, pend, stall;
    logic [31:0] rd_gpr, seg_base, rd_ctrl, flags, ip;
    logic [79:0] rd_fpr;
    logic [63:0] rd_media;
    logic [15:0] rd_seg, fsw, fcw, ftw;
    logic [12:0] sel_idx;
    logic [1:0] rpl;
    logic [2:0] br_cnt;
    int err_total = 0, num_checks = 0, cyc = 0;
    arf_regfile #(.MAX_BR(MAX_BR)) dut_u (.CLK_SYS(clk_sys), .RST(rst), .GPR_WR(gpr_wr),
        .FPR_WR(fpr_wr), .MEDIA_WR(media_wr), .SEG_WR_EN(seg_en), .SEG_WR_IDX(seg_idx),
        .SEG_WR_DATA(seg_data), .FLAGS_WR_EN(flags_en), .FLAGS_WR_DATA(flags_data),
        .CTRL_WR_EN(ctrl_en), .CTRL_WR_IDX(ctrl_idx), .CTRL_WR_DATA(ctrl_data),
        .FSW_WR_EN(fw_en[0]), .FSW_WR_DATA(fw_data), .FCW_WR_EN(fw_en[1]), .FCW_WR_DATA(fw_data),
        .FTW_WR_EN(fw_en[2]), .FTW_WR_DATA(fw_data), .IP_OP(ip_op), .IP_DATA(ip_data),
        .OPSIZE32(opsize32), .BR_ISSUE(br_issue), .BR_RESOLVE(br_resolve),
        .BR_MISPREDICT(br_mispredict), .RD_GPR_IDX(rd_gpr_idx), .RD_GPR_WIDTH(rd_width),
        .RD_FPR_IDX(rd_fpr_idx), .RD_SEG_IDX(rd_seg_idx), .RD_CTRL_IDX(rd_ctrl_idx),
        .RD_GPR_DATA(rd_gpr), .RD_FPR_DATA(rd_fpr), .RD_MEDIA_DATA(rd_media),
        .RD_SEG_DATA(rd_seg), .RD_SEG_BASE(seg_base), .RD_SEG_SEL_INDEX(sel_idx),
        .RD_SEG_SEL_TABLE(sel_tbl), .RD_SEG_SEL_RPL(rpl), .RD_CTRL_DATA(rd_ctrl),
        .FLAGS(flags), .FSW(fsw), .FCW(fcw), .FTW(ftw), .INSN_PTR(ip),
        .SPEC_PENDING(pend), .BR_STALL(stall), .BR_COUNT(br_cnt));
    arf_branch_model br_u (.clk(clk_sys), .br_stall(stall), .br_issue(br_issue),
        .br_resolve(br_resolve), .br_mispredict(br_mispredict));
    initial forever #12.5 clk_sys = ~clk_sys;
    task automatic end_sim;
        $display("checks=%0d mismatches=%0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    // The ceiling is over forty times the length of the whole sequence.
    always @(posedge clk_sys) begin
        cyc++;
        if (cyc == 3000) begin
            err_total++;
            end_sim;
        end
    end
    task automatic chk(input logic [79:0] got, input logic [79:0] exp);
        num_checks++;
        if (got !== exp) begin
            err_total++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(negedge clk_sys);
    endtask
    // Two edges per write, so the registered outputs already show it on return.
    task automatic gw(input logic [2:0] i, input arf_width_t w, input logic [31:0] d);
        gpr_wr = '{en: 1'b1, idx: i, width: w, data: d};
        tick(1);
        gpr_wr.en = 1'b0;
        tick(1);
    endtask
    task automatic t_views;
        logic [31:0] vexp [4] = '{32'h1122_ccdd, 32'h0000_ccdd, 32'h0000_00cc, 32'h0000_00dd};
        gw(3'h0, ARF_W32, 32'h1122_3344);
        gw(3'h0, ARF_W16, 32'haabb_aabb);
        gw(3'h0, ARF_B_HI, 32'h0000_cccc);
        gw(3'h0, ARF_B_LO, 32'h0000_dddd);
        for (int k = 0; k < 4; k++) begin
            rd_width = arf_width_t'(k);
            tick(1);
            chk(rd_gpr, vexp[k]);
        end
        rd_gpr_idx = 3'h5;
        gw(3'h5, ARF_W32, 32'h89ab_cdef);
        gw(3'h5, ARF_B_LO, 32'h0000_1111);
        chk(rd_gpr, 32'h0000_0000);
        rd_width = ARF_W16;
        tick(1);
        chk(rd_gpr, 32'h0000_cdef);
        $display("TEST views done");
    endtask
    task automatic t_spec;
        rd_gpr_idx = 3'h0;
        rd_width = ARF_W32;
        rd_fpr_idx = 3'h2;
        br_u.pulse(3'b001, 1'b0);
        br_u.pulse(3'b000, 1'b0);
        chk({pend, br_cnt}, {1'b1, 3'h1});
        media_wr = '{en: 1'b1, idx: 3'h2, data: 64'h0123_4567_89ab_cdef};
        gw(3'h0, ARF_W32, 32'hdead_beef);
        media_wr.en = 1'b0;
        chk(rd_fpr, 80'hffff_0123_4567_89ab_cdef);
        br_u.pulse(3'b100, 1'b0);
        br_u.pulse(3'b000, 1'b0);
        chk({rd_gpr, rd_fpr[63:0], br_cnt}, {32'h1122_ccdd, 64'h0, 3'h0});
        br_u.pulse(3'b001, 1'b0);
        br_u.pulse(3'b000, 1'b0);
        gw(3'h0, ARF_W32, 32'h0000_0042);
        br_u.pulse(3'b010, 1'b0);
        br_u.pulse(3'b100, 1'b0);
        br_u.pulse(3'b000, 1'b0);
        chk({rd_gpr, br_cnt}, {32'h0000_0042, 3'h0});
        $display("TEST speculation done");
    endtask
    task automatic t_cap;
        for (int k = 0; k < MAX_BR + 2; k++) br_u.pulse(3'b001, k >= MAX_BR);
        br_u.pulse(3'b000, 1'b0);
        chk({stall, br_cnt}, {1'b1, 3'h7});
        br_u.pulse(3'b010, 1'b0);
        br_u.pulse(3'b011, 1'b0);
        br_u.pulse(3'b000, 1'b0);
        chk({stall, br_cnt}, {1'b0, 3'h6});
        br_u.pulse(3'b100, 1'b0);
        br_u.pulse(3'b000, 1'b0);
        chk({pend, br_cnt}, {1'b0, 3'h0});
        $display("TEST branch cap done");
    endtask
    task automatic t_misc;
        rd_seg_idx = 3'h2;
        {seg_en, seg_idx, seg_data} = {1'b1, 3'h2, 16'h1237};
        {flags_en, flags_data, fw_en, fw_data} = {1'b1, 32'h0000_0403, 3'h7, 16'h5a5a};
        {ip_op, ip_data, opsize32} = {ARF_IP_XFER, 32'h1234_5678, 1'b0};
        tick(1);
        {seg_en, flags_en, fw_en, ip_op} = {1'b0, 1'b0, 3'h0, ARF_IP_NONE};
        tick(1);
        chk({rd_seg, seg_base}, {16'h1237, 32'h0001_2370});
        chk({sel_idx, sel_tbl, rpl}, {13'h0246, 1'b1, 2'h3});
        chk({flags, fsw, fcw, ftw}, {32'h0000_0403, 48'h5a5a_5a5a_5a5a});
        chk(ip, 32'h0000_5678);
        {ctrl_en, ctrl_data, ip_op, opsize32} = {1'b1, 32'h6000_0011, ARF_IP_SEQ, 1'b1};
        tick(1);
        {ctrl_en, ip_op, ip_data} = {1'b0, ARF_IP_NONE, 32'h0000_0000};
        tick(2);
        chk({seg_base, ip}, {32'h0, 32'h1234_5678});
        $display("TEST segments and pointer done");
    endtask
    initial begin
        tick(20);
        rst = 1'b0;
        tick(2);
        chk({flags, fcw, ftw, fsw}, {32'h0000_0002, 48'h037f_ffff_0000});
        chk({ip, rd_seg, rd_ctrl}, {32'h0000_fff0, 16'hf000, 32'h6000_0010});
        $display("TEST reset done");
        t_views;
        t_spec;
        t_cap;
        t_misc;
        end_sim;
    end
endmodule
